// >>> design/boost_timing_pkg.sv
package boost_timing_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DRV_ENABLE   = 8'h01;
    localparam logic [7:0] ADDR_L1_DIVIDER   = 8'h09;
    localparam logic [7:0] ADDR_L2_DIVIDER   = 8'h0a;
    localparam logic [7:0] ADDR_L1_PHASE_EN  = 8'h0b;
    localparam logic [7:0] ADDR_L2_PHASE_EN  = 8'h0c;
    localparam logic [7:0] ADDR_L1_TIMING    = 8'h0d;
    localparam logic [7:0] ADDR_L2_TIMING    = 8'h0e;
    localparam logic [7:0] ADDR_DRV_LOOP     = 8'h0f;
    localparam logic [7:0] ADDR_DRV_ROUTE    = 8'h10;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         NUM_PHASES        = 4;
    localparam int         DELAY_MSB         = 7;
    localparam int         DELAY_LSB         = 3;
    localparam int         OFF_MSB           = 2;
    localparam int         OFF_LSB           = 0;
    localparam int         ROUTE_W           = 2;
    localparam logic [3:0] NIBBLE_RESET      = 4'h0;
    localparam logic [7:0] BYTE_RESET        = 8'h00;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;
    localparam logic [3:0] RESERVED_READ     = 4'h0;
    localparam logic [2:0] OFF_ZERO_CODE     = 3'h0;
    localparam logic [2:0] OFF_ZERO_PERIODS  = 3'h1;

    typedef enum logic [1:0] {
        LOOP_IDLE = 2'b01,
        LOOP_RUN  = 2'b10
    } loop_state_type;

endpackage

// >>> design/multiphase_boost_phase_timing.sv
`timescale 1ns/1ps
module multiphase_boost_phase_timing
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       config_complete,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic      [3:0] gate_drv
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic [3:0] drv_on_r;
    logic [7:0] loop1_divide_value_r;
    logic [7:0] loop2_divide_value_r;
    logic [3:0] loop1_phase_en_r;
    logic [3:0] loop2_phase_en_r;
    logic [7:0] loop1_timing_r;
    logic [7:0] loop2_timing_r;
    logic [3:0] drv_loop_assoc_r;
    logic [7:0] drv_route_sel_r;
    logic       wr_ok;
    logic [7:0] rdata_nxt;
    logic [3:0] gate_nxt;

    phase_cfg_if loop1_if ();
    phase_cfg_if loop2_if ();

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    assign wr_ok = reg_wr && !config_complete;

    // Each register has its own process, so a write only touches the one it hits.
    // Reserved upper bits of the nibble registers are dropped on write.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            drv_on_r <= boost_timing_pkg::NIBBLE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_DRV_ENABLE))
            drv_on_r <= reg_wdata[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loop1_divide_value_r <= boost_timing_pkg::BYTE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_L1_DIVIDER))
            loop1_divide_value_r <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loop2_divide_value_r <= boost_timing_pkg::BYTE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_L2_DIVIDER))
            loop2_divide_value_r <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loop1_phase_en_r <= boost_timing_pkg::NIBBLE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_L1_PHASE_EN))
            loop1_phase_en_r <= reg_wdata[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loop2_phase_en_r <= boost_timing_pkg::NIBBLE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_L2_PHASE_EN))
            loop2_phase_en_r <= reg_wdata[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loop1_timing_r <= boost_timing_pkg::BYTE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_L1_TIMING))
            loop1_timing_r <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loop2_timing_r <= boost_timing_pkg::BYTE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_L2_TIMING))
            loop2_timing_r <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            drv_loop_assoc_r <= boost_timing_pkg::NIBBLE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_DRV_LOOP))
            drv_loop_assoc_r <= reg_wdata[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            drv_route_sel_r <= boost_timing_pkg::BYTE_RESET;
        else if (wr_ok && hit(reg_addr, boost_timing_pkg::ADDR_DRV_ROUTE))
            drv_route_sel_r <= reg_wdata;
    end

    // ------------------------------------------------------------
    // Register read-back, registered
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = boost_timing_pkg::READ_UNMAPPED;
        if (hit(reg_addr, boost_timing_pkg::ADDR_DRV_ENABLE))
            rdata_nxt = {boost_timing_pkg::RESERVED_READ, drv_on_r};
        else if (hit(reg_addr, boost_timing_pkg::ADDR_L1_DIVIDER))
            rdata_nxt = loop1_divide_value_r;
        else if (hit(reg_addr, boost_timing_pkg::ADDR_L2_DIVIDER))
            rdata_nxt = loop2_divide_value_r;
        else if (hit(reg_addr, boost_timing_pkg::ADDR_L1_PHASE_EN))
            rdata_nxt = {boost_timing_pkg::RESERVED_READ, loop1_phase_en_r};
        else if (hit(reg_addr, boost_timing_pkg::ADDR_L2_PHASE_EN))
            rdata_nxt = {boost_timing_pkg::RESERVED_READ, loop2_phase_en_r};
        else if (hit(reg_addr, boost_timing_pkg::ADDR_L1_TIMING))
            rdata_nxt = loop1_timing_r;
        else if (hit(reg_addr, boost_timing_pkg::ADDR_L2_TIMING))
            rdata_nxt = loop2_timing_r;
        else if (hit(reg_addr, boost_timing_pkg::ADDR_DRV_LOOP))
            rdata_nxt = {boost_timing_pkg::RESERVED_READ, drv_loop_assoc_r};
        else if (hit(reg_addr, boost_timing_pkg::ADDR_DRV_ROUTE))
            rdata_nxt = drv_route_sel_r;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= boost_timing_pkg::BYTE_RESET;
        else
            reg_rdata <= rdata_nxt;
    end

    // ------------------------------------------------------------
    // Two phase logics on the one clock
    // ------------------------------------------------------------
    assign loop1_if.divide_value = loop1_divide_value_r;
    assign loop1_if.step_delay   = loop1_timing_r[boost_timing_pkg::DELAY_MSB:
                                                  boost_timing_pkg::DELAY_LSB];
    assign loop1_if.off_interval = loop1_timing_r[boost_timing_pkg::OFF_MSB:
                                                  boost_timing_pkg::OFF_LSB];
    assign loop1_if.phase_enable = loop1_phase_en_r;
    assign loop2_if.divide_value = loop2_divide_value_r;
    assign loop2_if.step_delay   = loop2_timing_r[boost_timing_pkg::DELAY_MSB:
                                                  boost_timing_pkg::DELAY_LSB];
    assign loop2_if.off_interval = loop2_timing_r[boost_timing_pkg::OFF_MSB:
                                                  boost_timing_pkg::OFF_LSB];
    assign loop2_if.phase_enable = loop2_phase_en_r;

    phase_sequencer u_loop1
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cfg     (loop1_if.gen)
    );

    phase_sequencer u_loop2
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cfg     (loop2_if.gen)
    );

    // ------------------------------------------------------------
    // Driver routing and enable
    // ------------------------------------------------------------
    for (genvar d = 0; d < boost_timing_pkg::NUM_PHASES; d++)
    begin : g_drv
        logic [1:0] sel;
        assign sel = drv_route_sel_r[d*boost_timing_pkg::ROUTE_W +: boost_timing_pkg::ROUTE_W];
        assign gate_nxt[d] = drv_on_r[d]
                           && (drv_loop_assoc_r[d] ? loop2_if.phase_on[sel]
                                                   : loop1_if.phase_on[sel]);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            gate_drv <= boost_timing_pkg::NIBBLE_RESET;
        else
            gate_drv <= gate_nxt;
    end

endmodule // multiphase_boost_phase_timing

// >>> design/phase_cfg_if.sv
`timescale 1ns/1ps
interface phase_cfg_if;
    logic [7:0] divide_value;
    logic [4:0] step_delay;
    logic [2:0] off_interval;
    logic [3:0] phase_enable;
    logic [3:0] phase_on;

    modport ctrl (output divide_value, output step_delay, output off_interval,
                  output phase_enable, input phase_on);
    modport gen  (input divide_value, input step_delay, input off_interval,
                  input phase_enable, output phase_on);
endinterface

// >>> design/phase_sequencer.sv
`timescale 1ns/1ps
module phase_sequencer
(
    input  wire logic   clk,
    input  wire logic   sys_rst,
    phase_cfg_if.gen    cfg
);

    // ------------------------------------------------------------
    // Next enabled phase, ascending and wrapping
    // ------------------------------------------------------------
    function automatic logic [1:0] next_phase(input logic [1:0] cur, input logic [3:0] en);
        logic [1:0] res;
        logic [1:0] cand;
        res = cur;
        for (int k = 3; k >= 1; k--)
        begin
            cand = cur + k[1:0];
            if (en[cand])
                res = cand;
        end
        return res;
    endfunction

    boost_timing_pkg::loop_state_type state_r;
    logic [7:0] div_cnt_r;
    logic       tick;
    logic [4:0] step_cnt_r;
    logic [1:0] cur_r;
    logic       step_go;
    logic [2:0] off_len;

    // ------------------------------------------------------------
    // Divided clock from the common oscillator
    // ------------------------------------------------------------
    assign tick = (div_cnt_r == cfg.divide_value);

    always_ff @(posedge clk)
    begin
        if (sys_rst || tick)
            div_cnt_r <= boost_timing_pkg::BYTE_RESET;
        else
            div_cnt_r <= div_cnt_r + 8'h01;
    end

    // ------------------------------------------------------------
    // Phase stepping
    // ------------------------------------------------------------
    assign step_go = tick && (step_cnt_r >= cfg.step_delay);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r    <= boost_timing_pkg::LOOP_IDLE;
            step_cnt_r <= 5'h00;
            cur_r      <= 2'h0;
        end
        else
        begin
            case (state_r)
                boost_timing_pkg::LOOP_IDLE:
                begin
                    step_cnt_r <= 5'h00;
                    if (cfg.phase_enable != boost_timing_pkg::NIBBLE_RESET)
                    begin
                        state_r <= boost_timing_pkg::LOOP_RUN;
                        cur_r   <= next_phase(2'h3, cfg.phase_enable);
                    end
                end
                boost_timing_pkg::LOOP_RUN:
                begin
                    if (cfg.phase_enable == boost_timing_pkg::NIBBLE_RESET)
                        state_r <= boost_timing_pkg::LOOP_IDLE;
                    else if (step_go)
                    begin
                        step_cnt_r <= 5'h00;
                        cur_r      <= next_phase(cur_r, cfg.phase_enable);
                    end
                    else if (tick)
                        step_cnt_r <= step_cnt_r + 5'h01;
                end
                default:
                    state_r <= boost_timing_pkg::LOOP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-phase off interval, started on each phase turn
    // ------------------------------------------------------------
    assign off_len = (cfg.off_interval == boost_timing_pkg::OFF_ZERO_CODE)
                   ? boost_timing_pkg::OFF_ZERO_PERIODS : cfg.off_interval;

    for (genvar p = 0; p < boost_timing_pkg::NUM_PHASES; p++)
    begin : g_phase
        logic [2:0] off_cnt_r;
        logic       start;
        assign start = (state_r == boost_timing_pkg::LOOP_RUN) && step_go
                     && (next_phase(cur_r, cfg.phase_enable) == 2'(p));

        always_ff @(posedge clk)
        begin
            if (sys_rst || !cfg.phase_enable[p])
                off_cnt_r <= 3'h0;
            else if (start)
                off_cnt_r <= off_len;
            else if (tick && off_cnt_r != 3'h0)
                off_cnt_r <= off_cnt_r - 3'h1;
        end

        assign cfg.phase_on[p] = (state_r == boost_timing_pkg::LOOP_RUN)
                               && cfg.phase_enable[p] && (off_cnt_r == 3'h0) && !start;
    end

endmodule // phase_sequencer

// >>> verif/gate_stage_model.sv
`timescale 1ns/1ps
module gate_stage_model
(
    input  wire logic       clk,
    input  wire logic [3:0] gate_drv,
    output int              rise_at [4],
    output int              period [4],
    output int              low_len [4],
    output int              rises [4]
);
    int         cyc = 0;
    int         fall_at [4];
    logic [3:0] prev = 4'h0;

    initial
    begin
        foreach (prev[d])
        begin
            rise_at[d] = 0;
            period[d] = 0;
            low_len[d] = 0;
            rises[d] = 0;
            fall_at[d] = 0;
        end
    end

    // Gate stages only record edges; they load nothing back onto the drive pins.
    always @(posedge clk)
    begin
        cyc++;
        foreach (prev[d])
        begin
            if (gate_drv[d] === 1'b1 && !prev[d])
            begin
                period[d] = cyc - rise_at[d];
                low_len[d] = cyc - fall_at[d];
                rise_at[d] = cyc;
                rises[d]++;
            end
            if (gate_drv[d] !== 1'b1 && prev[d])
                fall_at[d] = cyc;
            prev[d] = (gate_drv[d] === 1'b1);
        end
    end
endmodule // gate_stage_model

// >>> verif/multiphase_boost_phase_timing_props.sv
`timescale 1ns/1ps
module multiphase_boost_phase_timing_props
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       config_complete,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic [3:0] gate_drv
);
    logic [7:0] shadow_r [0:16];
    logic [7:0] exp_rd;
    logic [3:0] route_ok;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            shadow_r <= '{default: boost_timing_pkg::BYTE_RESET};
        else if (reg_wr && !config_complete && reg_addr <= 8'h10)
            shadow_r[reg_addr[4:0]] <= reg_wdata;
    end

    always_comb
    begin
        exp_rd = boost_timing_pkg::READ_UNMAPPED;
        if (reg_addr inside {8'h01, 8'h0b, 8'h0c, 8'h0f})
            exp_rd = {4'h0, shadow_r[reg_addr[4:0]][3:0]};
        else if (reg_addr inside {8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h10})
            exp_rd = shadow_r[reg_addr[4:0]];
    end

    // Tells whether the phase a driver is routed to is enabled in its loop.
    always_comb
    begin
        for (int d = 0; d < 4; d++)
            route_ok[d] = shadow_r[shadow_r[15][d] ? 12 : 11][shadow_r[16][2 * d +: 2]];
    end

    a_read_matches: assert property (1'b1 |=> reg_rdata == $past(exp_rd))
        else $error("read data differs from register value");
    a_reserved_clear: assert property (reg_addr inside {8'h01, 8'h0b, 8'h0c, 8'h0f}
        |=> reg_rdata[7:4] == boost_timing_pkg::RESERVED_READ)
        else $error("reserved bits read nonzero");
    a_drive_needs_on: assert property ((gate_drv & ~$past(shadow_r[1][3:0])) == 4'h0)
        else $error("disabled driver active");
    a_idle_no_phase: assert property ((shadow_r[11][3:0] == 4'h0
        && shadow_r[12][3:0] == 4'h0) [*3] |-> gate_drv == 4'h0)
        else $error("gate active with no phase enabled");
    a_route_source: assert property (gate_drv[0] |-> $past(route_ok[0])
        || $past(route_ok[0], 2) || $past(route_ok[0], 3))
        else $error("driver 1 active from a disabled phase");
    a_assoc_loop: assert property (gate_drv[1] && shadow_r[15][1]
        |-> $past(shadow_r[12][3:0], 3) != 4'h0)
        else $error("driver 2 active from an idle loop 2");
    a_reset_quiet: assert property ($fell(sys_rst) |-> gate_drv == 4'h0
        && reg_rdata == boost_timing_pkg::BYTE_RESET)
        else $error("outputs not cleared by reset");
    a_off_min: assert property ($fell(gate_drv[0]) |=> !gate_drv[0])
        else $error("off interval too short");
endmodule // multiphase_boost_phase_timing_props

bind multiphase_boost_phase_timing multiphase_boost_phase_timing_props i_props (.clk(clk),
    .sys_rst(sys_rst), .config_complete(config_complete), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gate_drv(gate_drv));

// >>> verif/multiphase_boost_phase_timing_tb.sv
`timescale 1ns/1ps
module multiphase_boost_phase_timing_tb;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       config_complete = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [3:0] gate_drv;
    int         rise_at [4];
    int         period [4];
    int         low_len [4];
    int         rises [4];
    int         err_count = 0;
    int         checks = 0;
    logic [7:0] addrs [9] = '{8'h01, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};

    always #25 clk = ~clk;

    multiphase_boost_phase_timing i_dut (.clk(clk), .sys_rst(sys_rst),
        .config_complete(config_complete), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gate_drv(gate_drv));
    gate_stage_model i_gates (.clk(clk), .gate_drv(gate_drv), .rise_at(rise_at),
        .period(period), .low_len(low_len), .rises(rises));

    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 check({24'h0, reg_rdata}, {24'h0, e});
    endtask

    // Resets the block, then writes all nine registers in table order.
    task automatic cfg(input logic [7:0] v [9]);
        @(posedge clk);
        sys_rst <= 1'b1;
        config_complete <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (v[i]) wr(addrs[i], v[i]);
    endtask

    task automatic wait_rises(input int d, input int n);
        int start = rises[d];
        for (int i = 0; i < 5000 && rises[d] < start + n; i++)
            @(posedge clk);
        if (rises[d] < start + n)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, rises[d] - start, n);
            finish_test();
        end
    endtask

    task automatic t_regs();
        logic [7:0] d [9] = '{8'h05, 8'h3c, 8'hc3, 8'h0a, 8'h06, 8'hf1, 8'h0e, 8'h09, 8'he4};
        cfg(d);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            foreach (d[i]) rd(addrs[i], i inside {0, 3, 4, 7} ? {4'h0, d[i][3:0]} : d[i]);
            @(posedge clk);
            config_complete <= 1'b1;
            foreach (d[i]) wr(addrs[i], ~d[i] & (i inside {0, 3, 4, 7} ? 8'h0f : 8'hff));
        end
    endtask

    task automatic t_periods();
        logic [7:0] dv [4] = '{8'h00, 8'h02, 8'hff, 8'h00};
        logic [7:0] tm [4] = '{8'h19, 8'h09, 8'h09, 8'hf9};
        logic [3:0] en [4] = '{4'h1, 4'h3, 4'h1, 4'hf};
        int         pd [4] = '{4, 12, 512, 128};
        for (int k = 0; k < 4; k++)
        begin
            cfg('{8'h01, dv[k], 8'h00, {4'h0, en[k]}, 8'h00, tm[k], 8'h00, 8'h00, 8'h00});
            wait_rises(0, 3);
            check(period[0], pd[k]);
        end
        @(posedge clk);
        config_complete <= 1'b1;
        wr(8'h0b, 8'h00);
        wait_rises(0, 2);
        check(period[0], 128);
        @(posedge clk);
        config_complete <= 1'b0;
        wr(8'h0b, 8'h00);
        repeat (8) @(posedge clk);
        #1 check({28'h0, gate_drv}, 32'h0);
    endtask

    task automatic t_route();
        logic [7:0] rt [2] = '{8'he4, 8'h1b};
        for (int k = 0; k < 2; k++)
        begin
            cfg('{8'h0f, 8'h01, 8'h00, 8'h0f, 8'h00, 8'h11, 8'h00, 8'h00, rt[k]});
            wait_rises(3, 3);
            for (int d = 1; d < 4; d++)
                check((rise_at[d] - rise_at[0] + 240) % 24, k ? 24 - 6 * d : 6 * d);
        end
    endtask

    task automatic t_loop2();
        int r2;
        cfg('{8'h0b, 8'h00, 8'h04, 8'h01, 8'h02, 8'h19, 8'h10, 8'h0a, 8'h44});
        r2 = rises[2];
        wait_rises(3, 3);
        check(period[0], 4);
        check(period[1], 15);
        check(period[3], 15);
        check(rises[2], r2);
    endtask

    task automatic t_off();
        logic [2:0] oc [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        int         lw [4];
        for (int k = 0; k < 4; k++)
        begin
            cfg('{8'h01, 8'h01, 8'h00, 8'h01, 8'h00, {5'h07, oc[k]}, 8'h00, 8'h00, 8'h00});
            wait_rises(0, 3);
            lw[k] = low_len[0];
        end
        check(lw[0], lw[1]);
        check(lw[2] - lw[1], 4);
        check(lw[3] - lw[1], 12);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_periods();
        t_route();
        t_loop2();
        t_off();
        finish_test();
    end
endmodule // multiphase_boost_phase_timing_tb
